// *** cla_alarm.sv ***
// Purpose: Five concentration limit alarm units behind an AXI4-Lite port.
// Assumes: One clock, synchronous active-high reset, inputs synchronous.
// Notes:   Concentrations arrive per channel with a one-cycle valid strobe.
//
// Local design decisions: the AXI4-Lite interface to the registers and the placing of the registers.
`timescale 1ns/1ps
module cla_alarm
   import cla_pkg::*;
#(
   parameter longint INHIBIT_CYCLES = CLA_INHIBIT_CYC
) (
   // Clock and control.
   input  wire logic                               clk,
   input  wire logic                               rst,
   input  wire logic                               ce,
   // Measurement channels.
   input  wire logic [CLA_CHANNELS-1:0][CLA_VAL_W-1:0] conc,
   input  wire logic [CLA_CHANNELS-1:0]            conc_valid,
   // Alarm outputs.
   output logic [CLA_UNITS-1:0]                    contact,
   output cla_ind_type [CLA_CHANNELS-1:0]          indication,
   // AXI4-Lite slave.
   input  wire logic [CLA_ADDR_W-1:0]              s_awaddr,
   input  wire logic                               s_awvalid,
   output logic                                    s_awready,
   input  wire logic [31:0]                        s_wdata,
   input  wire logic [3:0]                         s_wstrb,
   input  wire logic                               s_wvalid,
   output logic                                    s_wready,
   output logic [1:0]                              s_bresp,
   output logic                                    s_bvalid,
   input  wire logic                               s_bready,
   input  wire logic [CLA_ADDR_W-1:0]              s_araddr,
   input  wire logic                               s_arvalid,
   output logic                                    s_arready,
   output logic [31:0]                             s_rdata,
   output logic [1:0]                              s_rresp,
   output logic                                    s_rvalid,
   input  wire logic                               s_rready
);

   if (INHIBIT_CYCLES < 1 || INHIBIT_CYCLES > 64'h0000_00ff_ffff_ffff)
      $error("INHIBIT_CYCLES out of range");

   localparam logic [15:0] HYST_MAX = 16'(CLA_FULL_SCALE / CLA_HYST_DIV);

   typedef struct packed {
      cla_unit_cfg_type [CLA_UNITS-1:0]      cfg;
      logic [15:0]                           hyst;
      logic [CLA_CHANNELS-1:0]               range;
      logic [CLA_UNITS-1:0]                  alarm;
      logic [CLA_UNITS-1:0]                  alarm_hi;
      logic [CLA_UNITS-1:0]                  alarm_lo;
      cla_ind_type [CLA_CHANNELS-1:0]        ind;
      logic [39:0]                           inh_cnt;
      logic                                  armed;
      cla_bus_type                           bus;
   } cla_state_type;

   cla_state_type s_reg;
   cla_state_type s_next;

   function automatic logic [31:0] rd_word(input cla_state_type s,
                                           input logic [7:0] a,
                                           output logic ok);
      logic [31:0] r;
      int          u;
      r  = 32'h0;
      ok = 1'b1;
      u  = int'(a[7:4]);
      if (a[1:0] != 2'h0) begin
         ok = 1'b0;
      end else if (a < CLA_HYST_ADDR) begin
         unique case (a[3:0])
            CLA_OFS_CFG: begin
               r[CLA_CFG_EN_BIT]           = s.cfg[u].enable;
               r[CLA_CFG_KIND_LO+:3]       = s.cfg[u].kind;
               r[CLA_CFG_CH_LO+:3]         = s.cfg[u].channel;
            end
            CLA_OFS_R0LIM: r = {s.cfg[u].upper[0], s.cfg[u].lower[0]};
            CLA_OFS_R1LIM: r = {s.cfg[u].upper[1], s.cfg[u].lower[1]};
            CLA_OFS_STAT:  r = {29'h0, s.alarm_lo[u], s.alarm_hi[u],
                                s.alarm[u]};
            default: ok = 1'b0;
         endcase
      end else if (a == CLA_HYST_ADDR) begin
         r = {16'h0, s.hyst};
      end else if (a == CLA_GSTAT_ADDR) begin
         r = {26'h0, s.armed, s.alarm};
      end else if (a == CLA_RANGE_ADDR) begin
         r = {27'h0, s.range};
      end else begin
         ok = 1'b0;
      end
      return r;
   endfunction

   always_comb begin
      logic [31:0]  wd;
      logic [31:0]  old;
      logic         ok;
      logic [15:0]  up;
      logic [15:0]  lo;
      logic [15:0]  v;
      logic         rg;
      logic         hi_c;
      logic         lo_c;
      int           u;
      wd   = 32'h0;
      old  = 32'h0;
      ok   = 1'b0;
      up   = 16'h0;
      lo   = 16'h0;
      v    = 16'h0;
      rg   = 1'b0;
      hi_c = 1'b0;
      lo_c = 1'b0;
      u    = 0;
      s_next = s_reg;

      // Power-up inhibit counter.
      if (!s_reg.armed) begin
         s_next.inh_cnt = s_reg.inh_cnt + 40'h1;
         if (s_reg.inh_cnt == 40'(INHIBIT_CYCLES - 1))
            s_next.armed = 1'b1;
      end

      // Alarm evaluation on fresh samples.
      for (int i = 0; i < CLA_UNITS; i++) begin
         v  = conc[s_reg.cfg[i].channel];
         rg = s_reg.range[s_reg.cfg[i].channel];
         up = s_reg.cfg[i].upper[rg];
         lo = s_reg.cfg[i].lower[rg];
         if (!s_reg.cfg[i].enable || !s_reg.armed) begin
            s_next.alarm_hi[i] = 1'b0;
            s_next.alarm_lo[i] = 1'b0;
         end else if (conc_valid[s_reg.cfg[i].channel]) begin
            // Upper test with hysteresis once closed.
            if (s_reg.alarm_hi[i])
               hi_c = ({1'b0, v} + {1'b0, s_reg.hyst}) >= {1'b0, up};
            else
               hi_c = v > up;
            lo_c = v < lo;
            if (up == 16'h0)
               hi_c = 1'b0;
            if (lo == 16'h0)
               lo_c = 1'b0;
            unique case (s_reg.cfg[i].kind)
               upper_only_kind, upper_upper_kind: begin
                  s_next.alarm_hi[i] = hi_c;
                  s_next.alarm_lo[i] = 1'b0;
               end
               lower_only_kind, lower_lower_kind: begin
                  s_next.alarm_hi[i] = 1'b0;
                  s_next.alarm_lo[i] = lo_c;
               end
               upper_or_lower_kind: begin
                  s_next.alarm_hi[i] = hi_c;
                  s_next.alarm_lo[i] = lo_c;
               end
               default: begin
                  s_next.alarm_hi[i] = 1'b0;
                  s_next.alarm_lo[i] = 1'b0;
               end
            endcase
         end
         s_next.alarm[i] = s_next.alarm_hi[i] | s_next.alarm_lo[i];
      end

      // Channel indications from active alarms.
      for (int c = 0; c < CLA_CHANNELS; c++) begin
         s_next.ind[c] = '0;
         for (int i = 0; i < CLA_UNITS; i++) begin
            if (s_next.alarm[i] && s_reg.cfg[i].channel == 3'(c)) begin
               unique case (s_reg.cfg[i].kind)
                  upper_upper_kind:
                     s_next.ind[c].upper_upper_alarm_indication = 1'b1;
                  lower_lower_kind:
                     s_next.ind[c].lower_lower_alarm_indication = 1'b1;
                  default: begin
                     if (s_next.alarm_hi[i])
                        s_next.ind[c].upper_alarm_indication = 1'b1;
                     if (s_next.alarm_lo[i])
                        s_next.ind[c].lower_alarm_indication = 1'b1;
                  end
               endcase
            end
         end
      end

      // Write channel: address and data may arrive in either order.
      if (s_awvalid && !s_reg.bus.aw_held) begin
         s_next.bus.awaddr  = s_awaddr;
         s_next.bus.aw_held = 1'b1;
      end
      if (s_wvalid && !s_reg.bus.w_held) begin
         s_next.bus.wdata  = s_wdata;
         s_next.bus.wstrb  = s_wstrb;
         s_next.bus.w_held = 1'b1;
      end
      if (s_reg.bus.bvalid && s_bready)
         s_next.bus.bvalid = 1'b0;
      if (s_reg.bus.aw_held && s_reg.bus.w_held && !s_reg.bus.bvalid) begin
         s_next.bus.aw_held = 1'b0;
         s_next.bus.w_held  = 1'b0;
         s_next.bus.bvalid  = 1'b1;
         old = rd_word(s_reg, s_reg.bus.awaddr, ok);
         for (int b = 0; b < 4; b++)
            wd[b*8+:8] = s_reg.bus.wstrb[b] ? s_reg.bus.wdata[b*8+:8]
                                            : old[b*8+:8];
         s_next.bus.bresp = ok ? CLA_RESP_OKAY : CLA_RESP_DECERR;
         u = int'(s_reg.bus.awaddr[7:4]);
         if (ok && s_reg.bus.awaddr < CLA_HYST_ADDR) begin
            unique case (s_reg.bus.awaddr[3:0])
               CLA_OFS_CFG: begin
                  if (wd[CLA_CFG_KIND_LO+:3] > 3'(lower_lower_kind) ||
                      wd[CLA_CFG_CH_LO+:3] >= 3'(CLA_CHANNELS)) begin
                     s_next.bus.bresp = CLA_RESP_SLVERR;
                  end else begin
                     s_next.cfg[u].enable  = wd[CLA_CFG_EN_BIT];
                     s_next.cfg[u].kind    = wd[CLA_CFG_KIND_LO+:3];
                     s_next.cfg[u].channel = wd[CLA_CFG_CH_LO+:3];
                  end
               end
               CLA_OFS_R0LIM, CLA_OFS_R1LIM: begin
                  rg = s_reg.bus.awaddr[3];
                  up = wd[CLA_LIM_UP_LO+:16];
                  lo = wd[15:0];
                  if (up < lo || up > CLA_FULL_SCALE) begin
                     s_next.bus.bresp = CLA_RESP_SLVERR;
                  end else begin
                     s_next.cfg[u].upper[rg] = up;
                     s_next.cfg[u].lower[rg] = lo;
                  end
               end
               default: s_next.bus.bresp = CLA_RESP_SLVERR;
            endcase
         end else if (ok && s_reg.bus.awaddr == CLA_HYST_ADDR) begin
            if (wd[15:0] > HYST_MAX)
               s_next.bus.bresp = CLA_RESP_SLVERR;
            else
               s_next.hyst = wd[15:0];
         end else if (ok && s_reg.bus.awaddr == CLA_RANGE_ADDR) begin
            s_next.range = wd[CLA_CHANNELS-1:0];
         end else if (ok) begin
            s_next.bus.bresp = CLA_RESP_SLVERR;
         end
      end

      // Read channel.
      if (s_reg.bus.rvalid && s_rready)
         s_next.bus.rvalid = 1'b0;
      if (s_arvalid && !s_reg.bus.rvalid) begin
         s_next.bus.rdata  = rd_word(s_reg, s_araddr, ok);
         s_next.bus.rresp  = ok ? CLA_RESP_OKAY : CLA_RESP_DECERR;
         s_next.bus.rvalid = 1'b1;
      end
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         s_reg <= '0;
      end else if (ce) begin
         s_reg <= s_next;
      end
   end

   assign contact    = s_reg.alarm;
   assign indication = s_reg.ind;
   assign s_awready  = !s_reg.bus.aw_held;
   assign s_wready   = !s_reg.bus.w_held;
   assign s_bvalid   = s_reg.bus.bvalid;
   assign s_bresp    = s_reg.bus.bresp;
   assign s_arready  = !s_reg.bus.rvalid;
   assign s_rvalid   = s_reg.bus.rvalid;
   assign s_rdata    = s_reg.bus.rdata;
   assign s_rresp    = s_reg.bus.rresp;

   property p_disabled_open;
      @(posedge clk) disable iff (rst)
         ce && !s_reg.cfg[0].enable |=> !contact[0];
   endproperty
   a_disabled_open: assert property (p_disabled_open)
      else $error("disabled unit 0 contact closed");

   property p_inhibit;
      @(posedge clk) disable iff (rst)
         !s_reg.armed |-> contact == '0;
   endproperty
   a_inhibit: assert property (p_inhibit)
      else $error("contact closed during power-up inhibit");

   property p_contact_kinds;
      @(posedge clk) disable iff (rst)
         contact[0] && $stable(s_reg.cfg[0])
         |-> indication[s_reg.cfg[0].channel] != '0;
   endproperty
   a_contact_kinds: assert property (p_contact_kinds)
      else $error("closed contact without a channel indication");

   property p_lower_kind_no_hi;
      @(posedge clk) disable iff (rst)
         ce && s_reg.cfg[0].kind == 3'(lower_only_kind) |=> !s_reg.alarm_hi[0];
   endproperty
   a_lower_kind_no_hi: assert property (p_lower_kind_no_hi)
      else $error("lower kind raised upper alarm");

   property p_upper_kind_no_lo;
      @(posedge clk) disable iff (rst)
         ce && s_reg.cfg[0].kind == 3'(upper_only_kind) |=> !s_reg.alarm_lo[0];
   endproperty
   a_upper_kind_no_lo: assert property (p_upper_kind_no_lo)
      else $error("upper kind raised lower alarm");

   property p_zero_upper;
      @(posedge clk) disable iff (rst)
         ce && s_reg.cfg[0].upper[s_reg.range[s_reg.cfg[0].channel]] == 16'h0
         |=> !s_reg.alarm_hi[0];
   endproperty
   a_zero_upper: assert property (p_zero_upper)
      else $error("zero upper limit raised an alarm");

   property p_limit_order;
      @(posedge clk) disable iff (rst)
         s_reg.cfg[0].upper[0] >= s_reg.cfg[0].lower[0];
   endproperty
   a_limit_order: assert property (p_limit_order)
      else $error("stored upper limit below lower limit");

   property p_hyst_max;
      @(posedge clk) disable iff (rst)
         s_reg.hyst <= HYST_MAX;
   endproperty
   a_hyst_max: assert property (p_hyst_max)
      else $error("hysteresis above one fifth of full scale");

   property p_hold_no_sample;
      @(posedge clk) disable iff (rst)
         ce && s_reg.armed && s_reg.cfg[0].enable
         && !conc_valid[s_reg.cfg[0].channel] |=> $stable(contact[0]);
   endproperty
   a_hold_no_sample: assert property (p_hold_no_sample)
      else $error("contact changed without a new sample");

   c_alarm: cover property (@(posedge clk) disable iff (rst)
      $rose(contact[0]));
   c_write: cover property (@(posedge clk) disable iff (rst)
      s_bvalid && s_bready && s_bresp == CLA_RESP_OKAY);
   c_reject: cover property (@(posedge clk) disable iff (rst)
      s_bvalid && s_bresp == CLA_RESP_SLVERR);

endmodule

// *** cla_meas_model.sv ***
// Purpose: Behavioural model of the measurement channels.
// Assumes: The bench asks for one sample at a time.
// Notes:   Values churn outside their strobe so stale data shows.
`timescale 1ns/1ps
module cla_meas_model
   import cla_pkg::*;
(
   // Clock.
   input  wire logic                              clk,
   // Bench request.
   input  wire logic                              go,
   input  wire logic [CLA_CH_W-1:0]               ch,
   input  wire logic [CLA_VAL_W-1:0]              val,
   // Channel outputs.
   output logic [CLA_CHANNELS-1:0][CLA_VAL_W-1:0] conc,
   output logic [CLA_CHANNELS-1:0]                conc_valid
);
   initial begin
      conc = '0;
      conc_valid = '0;
   end
   // A value only counts in the cycle of its strobe.
   always @(posedge clk) begin
      conc <= ~conc;
      conc_valid <= '0;
      if (go) begin
         conc[ch] <= val;
         conc_valid[ch] <= 1'h1;
      end
   end
endmodule

// *** cla_pkg.sv ***
// Purpose: Shared constants and types for the concentration limit alarm.
// Assumes: 125 MHz clock, AXI4-Lite register access, 16-bit values.
// Notes:   Register offsets are byte addresses of aligned 32-bit words.
package cla_pkg;

   localparam int CLA_UNITS      = 5;
   localparam int CLA_CHANNELS   = 5;
   localparam int CLA_VAL_W      = 16;
   localparam int CLA_CH_W       = 3;
   localparam int CLA_ADDR_W     = 8;
   localparam int CLA_RANGES     = 2;

   // Full scale of every range, in value units.
   localparam logic [15:0] CLA_FULL_SCALE = 16'h2710;
   // Hysteresis may reach one fifth of full scale.
   localparam int CLA_HYST_DIV   = 5;

   // Power-up inhibit time and its cycle count at 125 MHz.
   localparam longint CLA_INHIBIT_MIN  = 10;
   localparam longint CLA_CLK_HZ       = 125000000;
   localparam longint CLA_INHIBIT_CYC  = CLA_INHIBIT_MIN * 60 * CLA_CLK_HZ;

   // Register map: unit u at CLA_UNIT_BASE + u * CLA_UNIT_STRIDE.
   localparam logic [7:0] CLA_UNIT_BASE   = 8'h00;
   localparam logic [7:0] CLA_UNIT_STRIDE = 8'h10;
   localparam logic [3:0] CLA_OFS_CFG     = 4'h0;
   localparam logic [3:0] CLA_OFS_R0LIM   = 4'h4;
   localparam logic [3:0] CLA_OFS_R1LIM   = 4'h8;
   localparam logic [3:0] CLA_OFS_STAT    = 4'hc;
   localparam logic [7:0] CLA_HYST_ADDR   = 8'h50;
   localparam logic [7:0] CLA_GSTAT_ADDR  = 8'h54;
   localparam logic [7:0] CLA_RANGE_ADDR  = 8'h58;

   // Unit configuration word fields.
   localparam int CLA_CFG_EN_BIT   = 0;
   localparam int CLA_CFG_KIND_LO  = 4;
   localparam int CLA_CFG_CH_LO    = 8;
   // Limit word: upper in [31:16], lower in [15:0].
   localparam int CLA_LIM_UP_LO    = 16;

   localparam logic [1:0] CLA_RESP_OKAY   = 2'h0;
   localparam logic [1:0] CLA_RESP_SLVERR = 2'h2;
   localparam logic [1:0] CLA_RESP_DECERR = 2'h3;

   typedef enum logic [2:0] {
      upper_only_kind,
      lower_only_kind,
      upper_or_lower_kind,
      upper_upper_kind,
      lower_lower_kind
   } cla_kind_type;

   typedef struct packed {
      logic               enable;
      logic [2:0]         kind;
      logic [2:0]         channel;
      logic [1:0][15:0]   upper;
      logic [1:0][15:0]   lower;
   } cla_unit_cfg_type;

   // Alarm indication per channel.
   typedef struct packed {
      logic upper_alarm_indication;
      logic lower_alarm_indication;
      logic upper_upper_alarm_indication;
      logic lower_lower_alarm_indication;
   } cla_ind_type;

   typedef struct packed {
      logic [7:0]  awaddr;
      logic        aw_held;
      logic [31:0] wdata;
      logic [3:0]  wstrb;
      logic        w_held;
      logic        bvalid;
      logic [1:0]  bresp;
      logic        rvalid;
      logic [31:0] rdata;
      logic [1:0]  rresp;
   } cla_bus_type;

endpackage

// *** test_concentration_limit_alarm.sv ***
// Purpose: Self-checking bench for the concentration limit alarm.
// Assumes: A short power-up inhibit set through INHIBIT_CYCLES.
// Notes:   Random units and samples with fixed corner cases.
`timescale 1ns/1ps
module test_concentration_limit_alarm
   import cla_pkg::*;
;
   localparam int          INH = 40;
   localparam logic [15:0] FS  = CLA_FULL_SCALE;
   // Design ports.
   logic                                   clk = 1'h0;
   logic                                   rst = 1'h1;
   logic                                   ce = 1'h1;
   logic [CLA_CHANNELS-1:0][CLA_VAL_W-1:0] conc;
   logic [CLA_CHANNELS-1:0]                conc_valid;
   logic [CLA_UNITS-1:0]                   contact;
   cla_ind_type [CLA_CHANNELS-1:0]         indication;
   logic [7:0]                             s_awaddr = 8'h0, s_araddr = 8'h0;
   logic [31:0]                            s_wdata = 32'h0, s_rdata;
   logic [3:0]                             s_wstrb = 4'hf;
   logic [1:0]                             s_bresp, s_rresp;
   logic                                   s_awvalid = 1'h0, s_wvalid = 1'h0;
   logic                                   s_arvalid = 1'h0, s_bready = 1'h0;
   logic                                   s_rready = 1'h0;
   logic                                   s_awready, s_wready, s_bvalid;
   logic                                   s_arready, s_rvalid;
   // Partner request and expected state.
   logic                                   go = 1'h0;
   logic [2:0]                             sch = 3'h0;
   logic [15:0]                            sval = 16'h0, hyst = 16'h0;
   logic [15:0]                            up [CLA_UNITS], lo [CLA_UNITS];
   logic [2:0]                             kind [CLA_UNITS] = '{default: '0};
   logic [2:0]                             uch [CLA_UNITS] = '{default: '0};
   logic [CLA_UNITS-1:0]                   en = '0, up_al = '0, lo_al = '0;
   logic                                   armed = 1'h0;
   int                                     num_errors = 0;
   int                                     n_compared = 0;

   always #4 clk = ~clk;

   cla_alarm #(.INHIBIT_CYCLES(INH)) dut (
      .clk, .rst, .ce, .conc, .conc_valid, .contact, .indication,
      .s_awaddr, .s_awvalid, .s_awready, .s_wdata, .s_wstrb, .s_wvalid,
      .s_wready, .s_bresp, .s_bvalid, .s_bready, .s_araddr, .s_arvalid,
      .s_arready, .s_rdata, .s_rresp, .s_rvalid, .s_rready);
   cla_meas_model meas (.clk, .go, .ch(sch), .val(sval), .conc, .conc_valid);

   task automatic tally_and_finish();
      $display("compared %0d mismatches %0d", n_compared, num_errors);
      if (num_errors == 0 && n_compared > 0)
         $display("Regression OK");
      else
         $display("Regression broken");
      $finish;
   endtask

   task automatic chk(input logic [31:0] g, input logic [31:0] e,
                      input string w);
      n_compared++;
      if (g !== e) begin
         num_errors++;
         $display("BAD %0t %s got %h want %h", $time, w, g, e);
      end
   endtask

   task automatic hang();
      num_errors++;
      $display("BAD %0t bus answer never came", $time);
      tally_and_finish();
   endtask

   function automatic logic [7:0] ua(input int u, input logic [3:0] o);
      return CLA_UNIT_BASE + 8'(u) * CLA_UNIT_STRIDE + {4'h0, o};
   endfunction

   task automatic wx(input logic [7:0] a, input logic [31:0] d,
                     input logic [1:0] er);
      int n;
      s_awaddr <= a;
      s_wdata <= d;
      s_awvalid <= 1'h1;
      s_wvalid <= 1'h1;
      s_bready <= 1'h1;
      for (n = 0; n < 50; n++) begin
         @(posedge clk);
         if (s_awready) s_awvalid <= 1'h0;
         if (s_wready) s_wvalid <= 1'h0;
         if (s_bvalid) break;
      end
      if (n == 50) hang();
      chk(s_bresp, er, "write response");
      s_bready <= 1'h0;
      @(posedge clk);
   endtask

   task automatic rx(input logic [7:0] a, input logic [31:0] ed,
                     input logic [1:0] er);
      int n;
      s_araddr <= a;
      s_arvalid <= 1'h1;
      s_rready <= 1'h1;
      for (n = 0; n < 50; n++) begin
         @(posedge clk);
         if (s_arready) s_arvalid <= 1'h0;
         if (s_rvalid) break;
      end
      if (n == 50) hang();
      chk(s_rresp, er, "read response");
      if (er == CLA_RESP_OKAY) chk(s_rdata, ed, "read data");
      s_rready <= 1'h0;
      @(posedge clk);
   endtask

   task automatic chk_alarm();
      logic [CLA_UNITS-1:0]           ec;
      cla_ind_type [CLA_CHANNELS-1:0] ei;
      logic [3:0]                     t;
      ec = '0;
      ei = '0;
      for (int u = 0; u < CLA_UNITS; u++) begin
         case (kind[u])
            upper_only_kind:     t = {up_al[u], 3'h0};
            lower_only_kind:     t = {1'h0, lo_al[u], 2'h0};
            upper_or_lower_kind: t = {up_al[u], lo_al[u], 2'h0};
            upper_upper_kind:    t = {2'h0, up_al[u], 1'h0};
            default:             t = {3'h0, lo_al[u]};
         endcase
         if (!en[u] || !armed) t = 4'h0;
         ec[u] = |t;
         ei[uch[u]] = ei[uch[u]] | t;
      end
      chk(contact, ec, "contact");
      chk(indication, ei, "indication");
   endtask

   task automatic smp(input int c, input logic [15:0] v);
      go <= 1'h1;
      sch <= 3'(c);
      sval <= v;
      @(posedge clk);
      go <= 1'h0;
      repeat (2) @(posedge clk);
      for (int u = 0; u < CLA_UNITS; u++)
         if (ce && en[u] && uch[u] == c) begin
            up_al[u] = up[u] != 0 && (v > up[u] ||
                       up_al[u] && v + hyst >= up[u]);
            lo_al[u] = lo[u] != 0 && v < lo[u];
         end
      chk_alarm();
   endtask

   task automatic setu(input int u, input logic [2:0] k, input int c,
                       input logic [15:0] hi, input logic [15:0] lw);
      wx(ua(u, CLA_OFS_CFG), 32'h0, CLA_RESP_OKAY);
      en[u] = 1'h0;
      wx(ua(u, CLA_OFS_R0LIM), {hi, lw}, CLA_RESP_OKAY);
      wx(ua(u, CLA_OFS_CFG), {21'h0, 3'(c), 1'h0, k, 4'h1},
         CLA_RESP_OKAY);
      {en[u], kind[u], uch[u], up[u], lo[u]} = {1'h1, k, 3'(c), hi, lw};
      up_al[u] = 1'h0;
      lo_al[u] = 1'h0;
   endtask

   initial begin
      logic [31:0] d;
      logic [15:0] hi, lw;
      int          i;
      logic [15:0] hv [5] = '{16'h03b6, 16'h0384, 16'h0383, 16'h03e8,
                              16'h03e9};
      d = $urandom(32'hb2ddf152);
      repeat (6) @(posedge clk);
      rst <= 1'h0;
      @(posedge clk);
      setu(0, upper_only_kind, 0, 16'h03e8, 16'h0);
      rx(CLA_GSTAT_ADDR, 32'h0, CLA_RESP_OKAY);
      smp(0, 16'h07d0);
      repeat (INH) @(posedge clk);
      armed = 1'h1;
      setu(0, upper_only_kind, 0, 16'h03e8, 16'h0);
      rx(CLA_GSTAT_ADDR, 32'h20, CLA_RESP_OKAY);
      wx(CLA_HYST_ADDR, 32'h64, CLA_RESP_OKAY);
      hyst = 16'h0064;
      smp(0, 16'h07d0);
      foreach (hv[j]) smp(0, hv[j]);
      ce <= 1'h0;
      smp(0, 16'h0064);
      ce <= 1'h1;
      wx(ua(0, CLA_OFS_CFG), 32'h0, CLA_RESP_OKAY);
      en[0] = 1'h0;
      repeat (2) @(posedge clk);
      chk_alarm();
      smp(0, 16'h07d0);
      setu(1, upper_or_lower_kind, 1, 16'h0bb8, 16'h07d0);
      wx(ua(1, CLA_OFS_R0LIM), 32'h03e807d0, CLA_RESP_SLVERR);
      wx(ua(1, CLA_OFS_R0LIM), 32'h27110000, CLA_RESP_SLVERR);
      rx(ua(1, CLA_OFS_R0LIM), 32'h0bb807d0, CLA_RESP_OKAY);
      smp(1, 16'h07cf);
      smp(1, 16'h0bb9);
      wx(ua(1, CLA_OFS_CFG), 32'h0, CLA_RESP_OKAY);
      s_wstrb <= 4'hc;
      wx(ua(1, CLA_OFS_R0LIM), 32'h0fa0ffff, CLA_RESP_OKAY);
      s_wstrb <= 4'hf;
      rx(ua(1, CLA_OFS_R0LIM), 32'h0fa007d0, CLA_RESP_OKAY);
      wx(ua(1, CLA_OFS_R1LIM), 32'h13880000, CLA_RESP_OKAY);
      wx(ua(1, CLA_OFS_CFG), 32'h121, CLA_RESP_OKAY);
      up_al[1] = 1'h0;
      wx(CLA_RANGE_ADDR, 32'h2, CLA_RESP_OKAY);
      up[1] = 16'h1388;
      lo[1] = 16'h0;
      smp(1, 16'h0bb9);
      wx(CLA_RANGE_ADDR, 32'h0, CLA_RESP_OKAY);
      {up[1], lo[1]} = 32'h0fa007d0;
      rx(8'h5c, 32'h0, CLA_RESP_DECERR);
      rx(8'h02, 32'h0, CLA_RESP_DECERR);
      wx(8'h5c, 32'h0, CLA_RESP_DECERR);
      wx(CLA_HYST_ADDR, 32'h7d1, CLA_RESP_SLVERR);
      for (i = 0; i < 8; i++) begin
         hyst = 16'($urandom % 2001);
         wx(CLA_HYST_ADDR, {16'h0, hyst}, CLA_RESP_OKAY);
         for (int u = 0; u < CLA_UNITS; u++) begin
            lw = 16'($urandom % (FS - hyst));
            hi = lw + hyst + 16'h1 +
                 16'($urandom % (FS - hyst - lw));
            d = $urandom % 5;
            if (d == 0) lw = 16'h0;
            if (d == 1) {hi, lw} = 32'h0;
            setu(u, 3'((u + i) % 5), $urandom % 5, hi, lw);
         end
         repeat (20) smp($urandom % 5, 16'($urandom % (FS + 1)));
      end
      tally_and_finish();
   end
endmodule
